// *** src/sbus_params.svh ***
// constants for the serial bus addressing and framing block
// assumes a 100 MHz clock_i and byte-wide frames in binary mode
`ifndef SBUS_PARAMS_SVH
`define SBUS_PARAMS_SVH

`define SBUS_ADDR_BCAST 8'h00
`define SBUS_ADDR_MAX 8'hf7
`define SBUS_FRAME_MIN 9'h004
`define SBUS_FRAME_MAX 9'h100
`define SBUS_DATA_MAX 8'hfc
`define SBUS_CRC_INIT 16'hffff
`define SBUS_CRC_POLY 16'ha001
`define SBUS_FC_WR_COIL 8'h05
`define SBUS_FC_WR_REG 8'h06
`define SBUS_FC_WR_COILS 8'h0f
`define SBUS_FC_WR_REGS 8'h10
`define SBUS_CLK_MHZ 100
`define SBUS_RESP_TIMEOUT_MS 1000
`define SBUS_TURNAROUND_MS 100
`define SBUS_MS_CYCLES(ms) ((ms) * 1000 * `SBUS_CLK_MHZ)

`endif

// *** src/sbus_pkg.sv ***
// types and shared arithmetic for both bus ends
// assumes sbus_params.svh is on the include path
`include "sbus_params.svh"

package sbus_pkg;

    typedef enum logic [7:0] {
        SM_IDLE = 8'h01,
        SM_ADDR = 8'h02,
        SM_FUNC = 8'h04,
        SM_DATA = 8'h08,
        SM_CRCL = 8'h10,
        SM_CRCH = 8'h20,
        SM_WAIT = 8'h40,
        SM_TURN = 8'h80
    } sbus_mst_state_t;

    typedef enum logic [6:0] {
        SS_IDLE = 7'h01,
        SS_TAKE = 7'h02,
        SS_SKIP = 7'h04,
        SS_RADDR = 7'h08,
        SS_RBODY = 7'h10,
        SS_RCRCL = 7'h20,
        SS_RCRCH = 7'h40
    } sbus_slv_state_t;

    // one byte of the reflected check code, low bit first
    function automatic logic [15:0] sbus_crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++)
        begin
            r = r[0] ? ((r >> 1) ^ `SBUS_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // write-type function codes, the only ones allowed by broadcast
    function automatic logic sbus_is_write(input logic [7:0] f);
        return (f == `SBUS_FC_WR_COIL) || (f == `SBUS_FC_WR_REG) ||
               (f == `SBUS_FC_WR_COILS) || (f == `SBUS_FC_WR_REGS);
    endfunction

    // individual slave address range, zero and reserved excluded
    function automatic logic sbus_is_slave_addr(input logic [7:0] a);
        return (a != `SBUS_ADDR_BCAST) && (a <= `SBUS_ADDR_MAX);
    endfunction

endpackage

// *** src/sbus_link_if.sv ***
// byte-stream link between the master end and one slave end
// assumes both ends share clock_i; the bench joins one slave
`timescale 1ns/1ps
`default_nettype none

interface sbus_link_if;
    // master to slave request bytes
    logic m2s_valid;
    logic [7:0] m2s_data;
    logic m2s_last;
    logic m2s_ready;
    // slave to master reply bytes
    logic s2m_valid;
    logic [7:0] s2m_data;
    logic s2m_last;
    logic s2m_ready;

    modport mst (output m2s_valid, m2s_data, m2s_last, s2m_ready,
                 input m2s_ready, s2m_valid, s2m_data, s2m_last);
    modport slv (input m2s_valid, m2s_data, m2s_last, s2m_ready,
                 output m2s_ready, s2m_valid, s2m_data, s2m_last);
endinterface

`default_nettype wire

// *** src/sbus_buf2.sv ***
// two-entry buffer with valid and ready on both sides
// assumes one clock; full drops in_ready, so nothing is lost
`timescale 1ns/1ps
`default_nettype none

module sbus_buf2 #(
    parameter int W = 10
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // filling side
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    // draining side
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    logic [W-1:0] mem_r [2];
    logic wp_r;
    logic rp_r;
    logic [1:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_r != 2'd2);
    assign out_valid_o = (cnt_r != 2'd0);
    assign out_data_o = mem_r[rp_r];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // storage, no reset needed for the words themselves
    always_ff @(posedge clock_i)
    begin
        if (push)
        begin
            mem_r[wp_r] <= in_data_i;
        end
    end

    // pointers and fill level
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_r <= 2'd0;
        end
        else
        begin
            wp_r <= wp_r ^ push;
            rp_r <= rp_r ^ pop;
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

`default_nettype wire

// *** src/sbus_slave.sv ***
// slave end: address filter, frame check and reply framing
// assumes the physical layer flags character errors on line_err_i
`timescale 1ns/1ps
`default_nettype none
`include "sbus_params.svh"

module sbus_slave
    import sbus_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // configuration and physical layer status
    input wire logic [7:0] own_addr_i,
    input wire logic line_err_i,
    // received request toward the application
    output logic rq_valid_o,
    output logic [7:0] rq_data_o,
    output logic rq_last_o,
    output logic rq_good_o,
    output logic rq_bcast_o,
    input wire logic rq_ready_i,
    // reply body from the application: function code then data
    input wire logic rp_valid_i,
    input wire logic [7:0] rp_data_i,
    input wire logic rp_last_i,
    output logic rp_ready_o,
    // reply pending flag for the application
    output logic rp_pending_o,
    // bus side
    sbus_link_if.slv link
);
    sbus_slv_state_t state_r;
    logic [15:0] crc_r;
    logic [15:0] crc_nxt;
    logic [8:0] cnt_r;
    logic err_r;
    logic bcast_r;
    logic own_ok;
    logic rx_take;
    logic buf_in_ready;
    logic buf_push;
    logic frame_good;
    logic [9:0] buf_in;
    logic [9:0] buf_out;
    logic tx_fire;

    ////////////////////////////////////////////////////////////////////
    // receive side

    // a misconfigured address is never answered, so it cannot clash
    assign own_ok = sbus_is_slave_addr(own_addr_i);
    assign rx_take = link.m2s_valid && link.m2s_ready;

    // only idle or mid-frame states listen; skip always drains
    always_comb
    begin
        case (state_r)
            SS_IDLE: link.m2s_ready = buf_in_ready;
            SS_TAKE: link.m2s_ready = buf_in_ready;
            SS_SKIP: link.m2s_ready = 1'b1;
            default: link.m2s_ready = 1'b0;
        endcase
    end

    // check code takes the request byte in idle and take, own_addr_i for the reply address, else rp_data_i
    always_comb
    begin
        if (state_r == SS_IDLE)
        begin
            crc_nxt = sbus_crc_step(`SBUS_CRC_INIT, link.m2s_data);
        end
        else if (state_r == SS_TAKE)
        begin
            crc_nxt = sbus_crc_step(crc_r, link.m2s_data);
        end
        else if (state_r == SS_RADDR)
        begin
            crc_nxt = sbus_crc_step(`SBUS_CRC_INIT, own_addr_i);
        end
        else
        begin
            crc_nxt = sbus_crc_step(crc_r, rp_data_i);
        end
    end

    // whole frame incl. check bytes leaves a zero residue
    assign frame_good = !err_r && !line_err_i && (crc_nxt == 16'h0000) &&
                        (cnt_r + 9'd1 >= `SBUS_FRAME_MIN) && (cnt_r < `SBUS_FRAME_MAX);

    // accepted frames only; the last word carries the verdict
    assign buf_push = rx_take && ((state_r == SS_TAKE) ||
                      ((state_r == SS_IDLE) && own_ok &&
                       ((link.m2s_data == own_addr_i) ||
                        (link.m2s_data == `SBUS_ADDR_BCAST))));
    assign buf_in = {link.m2s_last, link.m2s_last && frame_good, link.m2s_data};

    sbus_buf2 #(
        .W(10)
    ) u_rq_buf (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .in_valid_i(buf_push),
        .in_data_i(buf_in),
        .in_ready_o(buf_in_ready),
        .out_valid_o(rq_valid_o),
        .out_data_o(buf_out),
        .out_ready_i(rq_ready_i)
    );

    assign rq_data_o = buf_out[7:0];
    assign rq_good_o = buf_out[8];
    assign rq_last_o = buf_out[9];
    assign rq_bcast_o = bcast_r;

    // frame byte count, saturating just above the longest frame
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_r <= 9'd0;
        end
        else if (rx_take && (state_r == SS_IDLE))
        begin
            cnt_r <= 9'd1;
        end
        else if (rx_take && (cnt_r <= `SBUS_FRAME_MAX))
        begin
            cnt_r <= cnt_r + 9'd1;
        end
    end

    // sticky frame error: char error or overlong frame
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            err_r <= 1'b0;
        end
        else if (rx_take && (state_r == SS_IDLE))
        begin
            err_r <= line_err_i;
        end
        else if (rx_take)
        begin
            err_r <= err_r || line_err_i || (cnt_r >= `SBUS_FRAME_MAX);
        end
    end

    // remember whether the frame was a broadcast
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            bcast_r <= 1'b0;
        end
        else if (rx_take && (state_r == SS_IDLE))
        begin
            bcast_r <= (link.m2s_data == `SBUS_ADDR_BCAST);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // reply side

    assign tx_fire = link.s2m_valid && link.s2m_ready;
    assign rp_pending_o = (state_r == SS_RADDR) || (state_r == SS_RBODY);

    // transmitter is silent outside the reply states
    always_comb
    begin
        link.s2m_valid = 1'b0;
        link.s2m_data = 8'h00;
        link.s2m_last = 1'b0;
        rp_ready_o = 1'b0;
        case (state_r)
            SS_RADDR:
            begin
                link.s2m_valid = 1'b1;
                link.s2m_data = own_addr_i;
            end
            SS_RBODY:
            begin
                link.s2m_valid = rp_valid_i;
                link.s2m_data = rp_data_i;
                rp_ready_o = link.s2m_ready;
            end
            SS_RCRCL:
            begin
                link.s2m_valid = 1'b1;
                link.s2m_data = crc_r[7:0];
            end
            SS_RCRCH:
            begin
                link.s2m_valid = 1'b1;
                link.s2m_data = crc_r[15:8];
                link.s2m_last = 1'b1;
            end
            default:
            begin
                link.s2m_valid = 1'b0;
            end
        endcase
    end

    // running check code, receive and transmit share it
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            crc_r <= `SBUS_CRC_INIT;
        end
        else if (rx_take || (tx_fire && ((state_r == SS_RADDR) || (state_r == SS_RBODY))))
        begin
            crc_r <= crc_nxt;
        end
    end

    // frame sequencer
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_r <= SS_IDLE;
        end
        else
        begin
            case (state_r)
                SS_IDLE:
                begin
                    if (rx_take && !link.m2s_last)
                    begin
                        state_r <= buf_push ? SS_TAKE : SS_SKIP;
                    end
                end
                SS_TAKE:
                begin
                    if (rx_take && link.m2s_last)
                    begin
                        // one reply per good unicast request only
                        state_r <= (frame_good && !bcast_r) ? SS_RADDR : SS_IDLE;
                    end
                end
                SS_SKIP:
                begin
                    if (rx_take && link.m2s_last)
                    begin
                        state_r <= SS_IDLE;
                    end
                end
                SS_RADDR:
                begin
                    if (tx_fire)
                    begin
                        state_r <= SS_RBODY;
                    end
                end
                SS_RBODY:
                begin
                    if (tx_fire && rp_last_i)
                    begin
                        state_r <= SS_RCRCL;
                    end
                end
                SS_RCRCL:
                begin
                    if (tx_fire)
                    begin
                        state_r <= SS_RCRCH;
                    end
                end
                SS_RCRCH:
                begin
                    if (tx_fire)
                    begin
                        state_r <= SS_IDLE;
                    end
                end
                default:
                begin
                    state_r <= SS_IDLE;
                end
            endcase
        end
    end
endmodule

`default_nettype wire

// *** src/sbus_master.sv ***
// master end: builds request frames, waits for reply or turnaround
// assumes the application holds the request header stable until taken
`timescale 1ns/1ps
`default_nettype none
`include "sbus_params.svh"

module sbus_master
    import sbus_pkg::*;
#(
    parameter int RESP_CYCLES = `SBUS_MS_CYCLES(`SBUS_RESP_TIMEOUT_MS),
    parameter int TURN_CYCLES = `SBUS_MS_CYCLES(`SBUS_TURNAROUND_MS)
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // request header
    input wire logic req_valid_i,
    input wire logic [7:0] req_addr_i,
    input wire logic [7:0] req_func_i,
    input wire logic [7:0] req_len_i,
    output logic req_ready_o,
    output logic req_bad_o,
    // request data bytes
    input wire logic wd_valid_i,
    input wire logic [7:0] wd_data_i,
    output logic wd_ready_o,
    // reply bytes and transaction status
    output logic rsp_valid_o,
    output logic [7:0] rsp_data_o,
    output logic rsp_last_o,
    output logic done_o,
    output logic done_ok_o,
    output logic timeout_o,
    output logic busy_o,
    // bus side
    sbus_link_if.mst link
);
    sbus_mst_state_t state_r;
    logic [7:0] addr_r;
    logic [7:0] func_r;
    logic [7:0] left_r;
    logic [15:0] crc_r;
    logic [31:0] tmr_r;
    logic [8:0] rcnt_r;
    logic [15:0] rcrc_r;
    logic [15:0] rcrc_nxt;
    logic wrong_r;
    logic req_ok;
    logic tx_fire;
    logic rx_fire;

    // reserved targets and broadcast reads are refused
    assign req_ok = (sbus_is_slave_addr(req_addr_i) ||
                     (req_addr_i == `SBUS_ADDR_BCAST) && sbus_is_write(req_func_i)) &&
                    (req_len_i <= `SBUS_DATA_MAX);
    assign req_ready_o = (state_r == SM_IDLE);
    assign req_bad_o = req_valid_i && req_ready_o && !req_ok;
    assign busy_o = (state_r != SM_IDLE);
    assign tx_fire = link.m2s_valid && link.m2s_ready;
    assign rx_fire = link.s2m_valid && link.s2m_ready;
    assign link.s2m_ready = 1'b1;
    assign wd_ready_o = (state_r == SM_DATA) && link.m2s_ready;

    ////////////////////////////////////////////////////////////////////
    // request framing: address, function, data, check low then high

    always_comb
    begin
        link.m2s_valid = 1'b1;
        link.m2s_last = 1'b0;
        case (state_r)
            SM_ADDR: link.m2s_data = addr_r;
            SM_FUNC: link.m2s_data = func_r;
            SM_DATA:
            begin
                link.m2s_valid = wd_valid_i;
                link.m2s_data = wd_data_i;
            end
            SM_CRCL: link.m2s_data = crc_r[7:0];
            SM_CRCH:
            begin
                link.m2s_data = crc_r[15:8];
                link.m2s_last = 1'b1;
            end
            default:
            begin
                link.m2s_valid = 1'b0;
                link.m2s_data = 8'h00;
            end
        endcase
    end

    // header capture and outgoing check code
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            addr_r <= 8'h00;
            func_r <= 8'h00;
            left_r <= 8'h00;
            crc_r <= `SBUS_CRC_INIT;
        end
        else if (req_valid_i && req_ready_o)
        begin
            addr_r <= req_addr_i;
            func_r <= req_func_i;
            left_r <= req_len_i;
            crc_r <= `SBUS_CRC_INIT;
        end
        else if (tx_fire && !link.m2s_last)
        begin
            crc_r <= (state_r == SM_CRCL) ? crc_r : sbus_crc_step(crc_r, link.m2s_data);
            left_r <= (state_r == SM_DATA) ? left_r - 8'd1 : left_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // reply checking

    assign rcrc_nxt = sbus_crc_step((rcnt_r == 9'd0) ? `SBUS_CRC_INIT : rcrc_r, link.s2m_data);

    // reply bytes out, registered; frame state tracked per byte
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rsp_valid_o <= 1'b0;
            rsp_data_o <= 8'h00;
            rsp_last_o <= 1'b0;
            rcnt_r <= 9'd0;
            rcrc_r <= `SBUS_CRC_INIT;
            wrong_r <= 1'b0;
        end
        else
        begin
            rsp_valid_o <= rx_fire && (state_r == SM_WAIT);
            rsp_data_o <= link.s2m_data;
            rsp_last_o <= rx_fire && link.s2m_last;
            if (rx_fire)
            begin
                rcrc_r <= rcrc_nxt;
                rcnt_r <= link.s2m_last ? 9'd0 : rcnt_r + 9'd1;
                if (rcnt_r == 9'd0)
                begin
                    wrong_r <= (link.s2m_data != addr_r);
                end
            end
        end
    end

    // status pulses
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            done_o <= 1'b0;
            done_ok_o <= 1'b0;
            timeout_o <= 1'b0;
        end
        else
        begin
            done_o <= (state_r == SM_WAIT) && rx_fire && link.s2m_last && !wrong_r;
            done_ok_o <= (state_r == SM_WAIT) && rx_fire && link.s2m_last && !wrong_r &&
                         (rcrc_nxt == 16'h0000) && (rcnt_r + 9'd1 >= `SBUS_FRAME_MIN);
            timeout_o <= (state_r == SM_WAIT) && (tmr_r == 32'd1) && !rx_fire;
        end
    end

    // response and turnaround timer
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tmr_r <= 32'd0;
        end
        else if (tx_fire && link.m2s_last)
        begin
            tmr_r <= (addr_r == `SBUS_ADDR_BCAST) ? TURN_CYCLES : RESP_CYCLES;
        end
        else if (tmr_r != 32'd0)
        begin
            tmr_r <= tmr_r - 32'd1; // wrong-slave replies keep it running
        end
    end

    // transaction sequencer: one open transaction at most
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_r <= SM_IDLE;
        end
        else
        begin
            case (state_r)
                SM_IDLE: if (req_valid_i && req_ok) state_r <= SM_ADDR;
                SM_ADDR: if (tx_fire) state_r <= SM_FUNC;
                SM_FUNC: if (tx_fire) state_r <= (left_r == 8'd0) ? SM_CRCL : SM_DATA;
                SM_DATA: if (tx_fire && (left_r == 8'd1)) state_r <= SM_CRCL;
                SM_CRCL: if (tx_fire) state_r <= SM_CRCH;
                SM_CRCH:
                begin
                    if (tx_fire)
                    begin
                        state_r <= (addr_r == `SBUS_ADDR_BCAST) ? SM_TURN : SM_WAIT;
                    end
                end
                SM_WAIT:
                begin
                    if ((rx_fire && link.s2m_last && !wrong_r) || (tmr_r == 32'd1))
                    begin
                        state_r <= SM_IDLE;
                    end
                end
                SM_TURN: if (tmr_r == 32'd1) state_r <= SM_IDLE;
                default: state_r <= SM_IDLE;
            endcase
        end
    end
endmodule

`default_nettype wire

// *** bench/sbus_link_monitor.sv ***
// link checker for the master and slave ends
// assumes one clock and an async active-high reset
`timescale 1ns/1ps
`default_nettype none

module sbus_link_monitor (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // request side
    input wire logic m2s_valid,
    input wire logic [7:0] m2s_data,
    input wire logic m2s_last,
    input wire logic m2s_ready,
    // reply side
    input wire logic s2m_valid,
    input wire logic [7:0] s2m_data,
    input wire logic s2m_last,
    input wire logic s2m_ready
);
    logic [8:0] m_cnt_r;
    logic [8:0] s_cnt_r;
    logic [7:0] addr_r;
    wire mt = m2s_valid & m2s_ready;
    wire st = s2m_valid & s2m_ready;

    // bytes so far per frame; zero means an address byte is next
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            m_cnt_r <= 9'h000;
            s_cnt_r <= 9'h000;
        end
        else
        begin
            m_cnt_r <= mt ? (m2s_last ? 9'h000 : m_cnt_r + 9'h001) : m_cnt_r;
            s_cnt_r <= st ? (s2m_last ? 9'h000 : s_cnt_r + 9'h001) : s_cnt_r;
        end
    end

    // target of the open request, kept to judge the reply
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            addr_r <= 8'h00;
        else if (mt && m_cnt_r == 9'h000)
            addr_r <= m2s_data;
    end

    ////////////////////////////////////////
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    AST_M2S_HOLD:
        assert property (m2s_valid && !m2s_ready |=> m2s_valid && $stable(m2s_data))
        else $error("request byte dropped");
    AST_NO_TALK:
        assert property (s2m_valid |-> !m2s_valid)
        else $error("reply during request");
    AST_ONE_OPEN:
        assert property (m2s_valid |-> s_cnt_r == 9'h000)
        else $error("request during reply");
    AST_REPLY_ADDR:
        assert property (s2m_valid && s_cnt_r == 9'h000 |-> s2m_data == addr_r)
        else $error("reply from wrong address");
    AST_BCAST_SILENT:
        assert property (mt && m2s_last && addr_r == 8'h00 |=> !s2m_valid [*8])
        else $error("reply to broadcast");
    AST_RSV_ADDR:
        assert property (mt && m_cnt_r == 9'h000 |-> m2s_data <= 8'hf7)
        else $error("reserved address sent");
    AST_M2S_LEN:
        assert property (mt && m2s_last |-> m_cnt_r inside {[9'h003:9'h0ff]})
        else $error("request length bad");
    AST_S2M_LEN:
        assert property (st && s2m_last |-> s_cnt_r inside {[9'h003:9'h0ff]})
        else $error("reply length bad");

    // main scenarios reached
    CV_REPLY: cover property (st && s2m_last);
    CV_BCAST: cover property (mt && m2s_last && addr_r == 8'h00);
    CV_STALL: cover property (m2s_valid && !m2s_ready);
endmodule

`default_nettype wire

// *** bench/tb_top.sv ***
// bench: master and slave ends joined by the link
// assumes the src files compile first
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic clock_i, rst_i, req_valid_i, rq_ready_i, line_err_i, rp_valid_i;
    logic [7:0] req_addr_i, req_func_i, req_len_i, rsp_data_o, rq_data_o, m_first, r_first;
    logic req_ready_o, req_bad_o, wd_ready_o, rsp_valid_o, rsp_last_o, done_o, done_ok_o;
    logic timeout_o, rq_valid_o, rq_last_o, rq_good_o, rq_bcast_o, rp_ready_o, rp_pending_o;
    logic got_bad, got_good, got_done, got_ok, got_to, seen_rq;
    int err_total, cmp_count, n_m2s, n_rsp;

    sbus_link_if sbus_link_if_inst ();
    sbus_master #(.RESP_CYCLES(200), .TURN_CYCLES(50)) sbus_master_inst (
        .clock_i, .rst_i, .req_valid_i, .req_addr_i, .req_func_i, .req_len_i, .req_ready_o,
        .req_bad_o, .wd_valid_i(rq_ready_i), .wd_data_i(8'h2a), .wd_ready_o, .rsp_valid_o,
        .rsp_data_o, .rsp_last_o, .done_o, .done_ok_o, .timeout_o, .busy_o(),
        .link(sbus_link_if_inst.mst));
    sbus_slave sbus_slave_inst (
        .clock_i, .rst_i, .own_addr_i(8'h11), .line_err_i, .rq_valid_o, .rq_data_o,
        .rq_last_o, .rq_good_o, .rq_bcast_o, .rq_ready_i, .rp_valid_i, .rp_data_i(8'h03),
        .rp_last_i(rp_valid_i), .rp_ready_o, .rp_pending_o, .link(sbus_link_if_inst.slv));
    sbus_link_monitor sbus_link_monitor_inst (
        .clock_i, .rst_i, .m2s_valid(sbus_link_if_inst.m2s_valid),
        .m2s_data(sbus_link_if_inst.m2s_data), .m2s_last(sbus_link_if_inst.m2s_last),
        .m2s_ready(sbus_link_if_inst.m2s_ready), .s2m_valid(sbus_link_if_inst.s2m_valid),
        .s2m_data(sbus_link_if_inst.s2m_data), .s2m_last(sbus_link_if_inst.s2m_last),
        .s2m_ready(sbus_link_if_inst.s2m_ready));

    ////////////////////////////////////////
    // 100 MHz clock
    initial
    begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    // application answers at once with a bare function code
    always @(negedge clock_i) rp_valid_i <= rp_pending_o;

    // record of one transaction as seen at the ports
    always @(posedge clock_i)
    begin
        if (sbus_link_if_inst.m2s_valid && sbus_link_if_inst.m2s_ready)
        begin
            if (n_m2s == 0)
                m_first = sbus_link_if_inst.m2s_data;
            n_m2s++;
        end
        seen_rq = seen_rq | rq_valid_o;
        if (rq_valid_o && rq_ready_i && rq_last_o)
            got_good = rq_good_o;
        if (rsp_valid_o && n_rsp++ == 0)
            r_first = rsp_data_o;
        got_done = got_done | done_o;
        got_ok = got_ok | done_ok_o;
        got_to = got_to | timeout_o;
    end

    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s exp %0h got %0h", name, exp, got);
        end
    endtask

    task automatic wrap_up();
        if (err_total == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // one request; s stalls the slave's reader for twelve cycles
    task automatic run(input logic [7:0] a, f, l, input logic e, s);
        int i;
        @(negedge clock_i);
        {n_m2s, n_rsp} = 0;
        got_good = 1'bx;
        {got_done, got_ok, got_to, seen_rq} = 4'h0;
        {req_addr_i, req_func_i, req_len_i, line_err_i, rq_ready_i} = {a, f, l, e, !s};
        req_valid_i = 1'b1;
        #1 got_bad = req_bad_o;
        @(negedge clock_i);
        req_valid_i = 1'b0;
        for (i = 0; i < 600 && req_ready_o !== 1'b1; i++)
        begin
            if (i == 12)
                rq_ready_i = 1'b1;
            @(negedge clock_i);
        end
        if (i == 600)
        begin
            err_total++;
            wrap_up();
        end
        repeat (2) @(negedge clock_i);
        line_err_i = 1'b0;
    endtask

    // longest frame with a stalled reader: the buffer must lose nothing
    task automatic t_unicast();
        run(8'h11, 8'h03, 8'hfc, 1'b0, 1'b1);
        check("req bytes", {got_bad, n_m2s[8:0]}, 10'h100);
        check("req addr", m_first, 8'h11);
        check("good", {got_good, rq_bcast_o}, 2'h2);
        check("rsp addr", r_first, 8'h11);
        check("rsp", {n_rsp[7:0], got_done, got_ok, got_to}, 11'h026);
    endtask

    // every write code by broadcast: taken, never answered
    task automatic t_bcast();
        logic [7:0] fc [4] = '{8'h05, 8'h06, 8'h0f, 8'h10};
        foreach (fc[k])
        begin
            run(8'h00, fc[k], 8'h00, 1'b0, 1'b0);
            check("bc", {got_bad, n_m2s[7:0], rq_bcast_o, got_good}, 11'h013);
            check("bc rsp", {n_rsp[7:0], got_done}, 9'h000);
        end
    endtask

    // refused requests never reach the line
    task automatic t_refuse();
        run(8'h00, 8'h03, 8'h00, 1'b0, 1'b0);
        check("bc read", {got_bad, n_m2s[7:0]}, 9'h100);
        run(8'hf8, 8'h03, 8'h00, 1'b0, 1'b0);
        check("rsv", {got_bad, n_m2s[7:0]}, 9'h100);
        run(8'h11, 8'h03, 8'hfd, 1'b0, 1'b0);
        check("long", {got_bad, n_m2s[7:0]}, 9'h100);
    endtask

    // top individual address, not ours: ignored, master times out
    task automatic t_other();
        run(8'hf7, 8'h03, 8'h00, 1'b0, 1'b0);
        check("other", {seen_rq, n_rsp[7:0], got_to}, 10'h001);
    endtask

    // character errors: handed over as bad, no reply
    task automatic t_error();
        run(8'h11, 8'h03, 8'h01, 1'b1, 1'b0);
        check("err", {got_good, n_rsp[7:0], got_done, got_to}, 11'h001);
    endtask

    initial
    begin
        {rst_i, req_valid_i, rq_ready_i, line_err_i} = 4'ha;
        {req_addr_i, req_func_i, req_len_i, err_total, cmp_count} = 0;
        repeat (16) @(posedge clock_i);
        @(negedge clock_i) rst_i = 1'b0;
        check("idle", req_ready_o, 1);
        t_unicast();
        t_bcast();
        t_refuse();
        t_other();
        t_error();
        wrap_up();
    end
endmodule

`default_nettype wire
